// >>> adc_ctl_defines.svh
`ifndef ADC_CTL_DEFINES_SVH
`define ADC_CTL_DEFINES_SVH

// register indices on the plain port
`define ADDR_CONTROL_TWO     4'h0
`define ADDR_SCAN_LIST       4'h1
`define ADDR_INT_STATUS      4'h2
`define ADDR_INT_MASK        4'h3

// control two field positions
`define REF_SEL_HI           15
`define REF_SEL_LO           13
`define SCAN_SEL_BIT         10
`define CHAN_CNT_HI          9
`define CHAN_CNT_LO          8
`define BUF_HALF_BIT         7
`define PER_EVENT_HI         6
`define PER_EVENT_LO         2
`define SPLIT_BUF_BIT        1
`define ALT_INPUT_BIT        0

// writable bits of control two; bit 7 is read-only, 12:11 unimplemented
`define CONTROL_TWO_WMASK    16'he77f
`define CONTROL_TWO_RESET    16'h0000
`define SCAN_LIST_RESET      16'h0000
`define INT_MASK_RESET       3'h0

// interrupt status bits
`define INT_GROUP_BIT        0
`define INT_DMA_BIT          1
`define INT_HALF_BIT         2
`endif

// >>> adc_ctl_pkg.sv
package adc_ctl_pkg;
	typedef logic [15:0] word_t;
	typedef logic [3:0]  addr_t;
	typedef logic [4:0]  count_t;
	typedef logic [3:0]  chan_t;
	typedef logic [2:0]  irq_t;

	typedef enum logic [1:0] {
		MUX_A = 2'b01,
		MUX_B = 2'b10
	} mux_phase_e;

	typedef enum logic [2:0] {
		REF_SUPPLY   = 3'b000,
		REF_EXT_POS  = 3'b001,
		REF_EXT_NEG  = 3'b010,
		REF_EXT_BOTH = 3'b011
	} ref_code_e;
endpackage

// >>> adc_seq_props.sv
module adc_seq_props (
	// clock and reset
	input wire logic               clk,
	input wire logic               reset,
	// register port
	input wire adc_ctl_pkg::addr_t addr,
	input wire adc_ctl_pkg::word_t wrData,
	input wire logic               wrStrobe,
	input wire logic               rdStrobe,
	input wire adc_ctl_pkg::word_t rdData,
	// converter status
	input wire logic               conversionDone,
	input wire logic               twelveBitMode,
	input wire logic               dmaAddressModeEnable,
	// watched outputs
	input wire logic               refHighExternal,
	input wire logic               refLowExternal,
	input wire adc_ctl_pkg::chan_t channelEnable,
	input wire logic               scanActive,
	input wire adc_ctl_pkg::chan_t scanInput,
	input wire logic               muxBActive,
	input wire logic               bufferHalf,
	input wire logic               dmaAddrIncrement,
	input wire logic               interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	import adc_ctl_pkg::*;
	word_t  ctlQ;
	irq_t   maskQ;
	count_t cntQ;
	logic   hit;
	logic   dmaHit;
	logic   scanExpQ;
	logic   refHiExpQ;
	logic   refLoExpQ;
	logic   rdCtlQ;
	chan_t  chanExpQ;
	word_t  rdExp;
	word_t  rdExpQ;
	assign hit = conversionDone &&
		(cntQ == (dmaAddressModeEnable ? ctlQ[6:2] : {1'b0, ctlQ[5:2]}));
	assign dmaHit = hit && dmaAddressModeEnable;
	assign rdExp = {ctlQ[15:13], 2'h0, ctlQ[10], twelveBitMode ? 2'h0 : ctlQ[9:8],
		bufferHalf, ctlQ[6:0]};
	////////////////////////////////////////////////////////////////////////////
	// shadow of the writable control two and mask registers
	always_ff @(posedge clk) begin
		if (reset) begin
			ctlQ <= 16'h0000;
			maskQ <= 3'h0;
		end else if (wrStrobe && addr == 4'h0)
			ctlQ <= wrData & 16'he77f;
		else if (wrStrobe && addr == 4'h3)
			maskQ <= wrData[2:0];
	end
	// conversions since the last threshold
	always_ff @(posedge clk) begin
		if (reset || (wrStrobe && addr <= 4'h1) || hit)
			cntQ <= 5'h00;
		else if (conversionDone)
			cntQ <= cntQ + 5'h01;
	end
	always_ff @(posedge clk) begin
		refHiExpQ <= !reset && (ctlQ[15:13] == 3'h1 || ctlQ[15:13] == 3'h3);
		refLoExpQ <= !reset && (ctlQ[15:13] == 3'h2 || ctlQ[15:13] == 3'h3);
		chanExpQ <= (reset || twelveBitMode || ctlQ[9:8] == 2'h0) ? 4'h1 :
			(ctlQ[9] ? 4'hf : 4'h3);
		rdCtlQ <= !reset && rdStrobe && addr == 4'h0;
		rdExpQ <= rdExp;
		scanExpQ <= !reset && ctlQ[10] && !muxBActive;
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence hitSeq;
		hit && maskQ[0] && !dmaAddressModeEnable;
	endsequence
	sequence quietMask;
		(maskQ == 3'h0)[*2];
	endsequence
	ref_decode_a: assert property (
		refHighExternal == refHiExpQ && refLowExternal == refLoExpQ)
		else $error("reference outputs disagree with control");
	chan_count_a: assert property (channelEnable == chanExpQ)
		else $error("channel enables disagree with control");
	read_back_a: assert property (rdCtlQ |-> rdData == rdExpQ)
		else $error("control read back wrong");
	split_off_a: assert property ((!ctlQ[1])[*2] |-> !bufferHalf)
		else $error("buffer half set outside split mode");
	irq_raise_a: assert property (hitSeq |-> ##[1:2] interrupt)
		else $error("no interrupt after threshold");
	irq_mask_a: assert property (quietMask |-> !interrupt)
		else $error("interrupt with all sources masked");
	dma_idle_a: assert property (!dmaHit |=> !dmaAddrIncrement)
		else $error("dma step without dma threshold");
	dma_step_a: assert property (dmaHit |=> dmaAddrIncrement)
		else $error("no dma step after threshold");
	scan_gate_a: assert property (scanActive == scanExpQ)
		else $error("scan active wrong");
endmodule

bind adc_sequence_control_two adc_seq_props u_props (
	.clk(clk), .reset(reset), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
	.rdStrobe(rdStrobe), .rdData(rdData), .conversionDone(conversionDone),
	.twelveBitMode(twelveBitMode), .dmaAddressModeEnable(dmaAddressModeEnable),
	.refHighExternal(refHighExternal),
	.refLowExternal(refLowExternal), .channelEnable(channelEnable),
	.scanActive(scanActive), .scanInput(scanInput), .muxBActive(muxBActive),
	.bufferHalf(bufferHalf), .dmaAddrIncrement(dmaAddrIncrement), .interrupt(interrupt)
);

// >>> adc_sequence_control_two.sv
`include "adc_ctl_defines.svh"

module adc_sequence_control_two (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// register port
	input  wire adc_ctl_pkg::addr_t  addr,
	input  wire adc_ctl_pkg::word_t  wrData,
	input  wire logic                wrStrobe,
	input  wire logic                rdStrobe,
	output adc_ctl_pkg::word_t       rdData,
	// converter status
	input  wire logic                conversionDone,
	input  wire logic                twelveBitMode,
	input  wire logic                dmaAddressModeEnable,
	// reference selection
	output logic                     refHighExternal,
	output logic                     refLowExternal,
	// channel and input selection
	output adc_ctl_pkg::chan_t       channelEnable,
	output logic                     scanActive,
	output adc_ctl_pkg::chan_t       scanInput,
	output logic                     muxBActive,
	// buffer and events
	output logic                     bufferHalf,
	output logic                     dmaAddrIncrement,
	output logic                     interrupt
);
	import adc_ctl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// register storage

	word_t      control_q;
	word_t      scanList_q;
	irq_t       intStatus_q;
	irq_t       intMask_q;
	word_t      rdData_q;
	logic       bufferHalf_q;
	logic       refHigh_q;
	logic       refLow_q;
	chan_t      chanEnable_q;
	logic       scanActive_q;
	mux_phase_e phase_q;
	logic       dmaIncr_q;
	logic       irq_q;

	logic       wrControl;
	logic       wrScan;
	logic       wrMask;
	logic       rdStatus;
	logic       dmaMode;
	logic       splitMode;
	logic       altMode;
	logic       scanSel;
	irq_t       intEvents;
	logic       groupHit;

	conv_step_if step ();

	////////////////////////////////////////////////////////////////////////////////
	// helper functions

	// reference decode: {high external, low external}
	function automatic logic [1:0] ref_decode(input logic [2:0] code);
		logic [1:0] res;
		res = 2'b00;
		if (!code[2]) begin
			unique case (ref_code_e'(code))
				REF_SUPPLY:   res = 2'b00;
				REF_EXT_POS:  res = 2'b10;
				REF_EXT_NEG:  res = 2'b01;
				REF_EXT_BOTH: res = 2'b11;
			endcase
		end
		return res;
	endfunction

	// channel count seen by logic and software
	function automatic logic [1:0] chan_count(input word_t ctl, input logic twelve);
		logic [1:0] res;
		res = twelve ? 2'b00 : ctl[`CHAN_CNT_HI:`CHAN_CNT_LO];
		return res;
	endfunction

	// channel enables from the count code
	function automatic chan_t chan_decode(input logic [1:0] cnt);
		chan_t res;
		if (cnt[1]) begin
			res = 4'hf;
		end else if (cnt[0]) begin
			res = 4'h3;
		end else begin
			res = 4'h1;
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// decode

	assign wrControl = wrStrobe && (addr == `ADDR_CONTROL_TWO);
	assign wrScan    = wrStrobe && (addr == `ADDR_SCAN_LIST);
	assign wrMask    = wrStrobe && (addr == `ADDR_INT_MASK);
	assign rdStatus  = rdStrobe && (addr == `ADDR_INT_STATUS);

	assign dmaMode   = dmaAddressModeEnable;
	assign splitMode = control_q[`SPLIT_BUF_BIT];
	assign altMode   = control_q[`ALT_INPUT_BIT];
	assign scanSel   = control_q[`SCAN_SEL_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// control two and scan list

	always_ff @(posedge clk) begin
		if (reset) begin
			control_q <= `CONTROL_TWO_RESET;
		end else if (wrControl) begin
			control_q <= wrData & `CONTROL_TWO_WMASK;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			scanList_q <= `SCAN_LIST_RESET;
		end else if (wrScan) begin
			scanList_q <= wrData;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reference and channel outputs

	always_ff @(posedge clk) begin
		if (reset) begin
			refHigh_q <= 1'b0;
			refLow_q  <= 1'b0;
		end else begin
			{refHigh_q, refLow_q} <= ref_decode(control_q[`REF_SEL_HI:`REF_SEL_LO]);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			chanEnable_q <= 4'h1;
		end else begin
			chanEnable_q <= chan_decode(chan_count(control_q, twelveBitMode));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sample multiplexer phase and scanning

	// with alternate input select the phase swaps after each conversion
	always_ff @(posedge clk) begin
		if (reset || wrControl) begin
			phase_q <= MUX_A;
		end else if (conversionDone && altMode) begin
			unique case (phase_q)
				MUX_A: phase_q <= MUX_B;
				MUX_B: phase_q <= MUX_A;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			scanActive_q <= 1'b0;
		end else begin
			scanActive_q <= scanSel && (phase_q == MUX_A);
		end
	end

	assign step.scanStep = conversionDone && scanSel && (phase_q == MUX_A);
	assign step.scanList = scanList_q;
	assign step.restart  = wrControl || wrScan;

	input_scan_stepper u_stepper (
		.clk   (clk),
		.reset (reset),
		.sc    (step.stepper)
	);

	////////////////////////////////////////////////////////////////////////////////
	// conversions per event

	// without DMA address mode the top bit of the field is ignored
	assign step.threshold = dmaMode ? control_q[`PER_EVENT_HI:`PER_EVENT_LO]
		: {1'b0, control_q[`PER_EVENT_HI-1:`PER_EVENT_LO]};
	assign step.advance   = conversionDone;

	conversion_counter u_counter (
		.clk   (clk),
		.reset (reset),
		.ev    (step.counter)
	);

	assign groupHit = step.hit;

	always_ff @(posedge clk) begin
		if (reset) begin
			dmaIncr_q <= 1'b0;
		end else begin
			dmaIncr_q <= groupHit && dmaMode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// buffer half

	// swaps halves at each group boundary, held at first half outside split mode
	always_ff @(posedge clk) begin
		if (reset || !splitMode) begin
			bufferHalf_q <= 1'b0;
		end else if (groupHit) begin
			bufferHalf_q <= !bufferHalf_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status and mask

	assign intEvents[`INT_GROUP_BIT] = groupHit && !dmaMode;
	assign intEvents[`INT_DMA_BIT]   = groupHit && dmaMode;
	assign intEvents[`INT_HALF_BIT]  = groupHit && splitMode;

	// an event in the clearing cycle survives
	always_ff @(posedge clk) begin
		if (reset) begin
			intStatus_q <= 3'h0;
		end else if (rdStatus) begin
			intStatus_q <= intEvents;
		end else begin
			intStatus_q <= intStatus_q | intEvents;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			intMask_q <= `INT_MASK_RESET;
		end else if (wrMask) begin
			intMask_q <= wrData[2:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(intStatus_q & intMask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read port

	always_ff @(posedge clk) begin
		if (reset) begin
			rdData_q <= 16'h0000;
		end else if (rdStrobe) begin
			unique case (addr)
				`ADDR_CONTROL_TWO: begin
					rdData_q <= {control_q[15:10],
						chan_count(control_q, twelveBitMode),
						bufferHalf_q, control_q[6:0]};
				end
				`ADDR_SCAN_LIST: rdData_q <= scanList_q;
				`ADDR_INT_STATUS: rdData_q <= {13'h0000, intStatus_q};
				`ADDR_INT_MASK: rdData_q <= {13'h0000, intMask_q};
				default: rdData_q <= 16'h0000;
			endcase
		end else begin
			rdData_q <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign rdData           = rdData_q;
	assign refHighExternal  = refHigh_q;
	assign refLowExternal   = refLow_q;
	assign channelEnable    = chanEnable_q;
	assign scanActive       = scanActive_q;
	assign scanInput        = step.scanIndex;
	// one-hot phase: bit 1 marks multiplexer B
	assign muxBActive       = phase_q[1];
	assign bufferHalf       = bufferHalf_q;
	assign dmaAddrIncrement = dmaIncr_q;
	assign interrupt        = irq_q;
endmodule

// >>> conv_step_if.sv
interface conv_step_if;
	import adc_ctl_pkg::*;
	logic   advance;
	logic   restart;
	count_t threshold;
	logic   hit;
	logic   scanStep;
	word_t  scanList;
	chan_t  scanIndex;

	modport ctrl (output advance, output restart, output threshold, output scanStep,
		output scanList, input hit, input scanIndex);
	modport counter (input advance, input restart, input threshold, output hit);
	modport stepper (input scanStep, input restart, input scanList, output scanIndex);
endinterface

// >>> conversion_counter.sv
module conversion_counter
	import adc_ctl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// events
	conv_step_if.counter ev
);
	count_t count_q;

	assign ev.hit = ev.advance && (count_q == ev.threshold);

	always_ff @(posedge clk) begin
		if (reset || ev.restart) begin
			count_q <= 5'h00;
		end else if (ev.hit) begin
			count_q <= 5'h00;
		end else if (ev.advance) begin
			count_q <= count_q + 5'h01;
		end
	end
endmodule

// >>> input_scan_stepper.sv
module input_scan_stepper
	import adc_ctl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// scan control
	conv_step_if.stepper sc
);
	chan_t index_q;

	// next enabled input after the current one, wrapping round
	function automatic chan_t next_input(input word_t list, input chan_t cur);
		chan_t res;
		chan_t probe;
		res = cur;
		for (int i = 16; i >= 1; i--) begin
			probe = cur + i[3:0];
			if (list[probe]) begin
				res = probe;
			end
		end
		return res;
	endfunction

	assign sc.scanIndex = index_q;

	always_ff @(posedge clk) begin
		if (reset || sc.restart) begin
			index_q <= next_input(sc.scanList, 4'hf);
		end else if (sc.scanStep) begin
			index_q <= next_input(sc.scanList, index_q);
		end
	end
endmodule

// >>> tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_ctl_pkg::*;
	logic  clk, reset, wrStrobe, rdStrobe, conversionDone, twelveBitMode;
	logic  refHighExternal, refLowExternal, scanActive, muxBActive, bufferHalf;
	logic  dmaAddrIncrement, interrupt, dmaAddressModeEnable;
	int    dmaSeen = 0;
	addr_t addr;
	word_t wrData, rdData;
	chan_t channelEnable, scanInput;
	int    miscompares = 0;
	int    checkCount = 0;
	int    nv[3] = '{0, 2, 15};
	`define CK(n, e, g) begin checkCount++; if ((g) !== (e)) begin miscompares++; \
		$display("[ERR] %s exp %h got %h", n, e, g); end end
	adc_sequence_control_two u_dut (
		.clk(clk), .reset(reset), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .conversionDone(conversionDone),
		.twelveBitMode(twelveBitMode), .dmaAddressModeEnable(dmaAddressModeEnable),
		.refHighExternal(refHighExternal),
		.refLowExternal(refLowExternal), .channelEnable(channelEnable),
		.scanActive(scanActive), .scanInput(scanInput), .muxBActive(muxBActive),
		.bufferHalf(bufferHalf), .dmaAddrIncrement(dmaAddrIncrement), .interrupt(interrupt)
	);
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// dma step pulses last one cycle, so count them
	always @(posedge clk) begin
		if (dmaAddrIncrement === 1'h1)
			dmaSeen++;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input addr_t a, input word_t d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'h1;
		@(posedge clk);
		wrStrobe <= 1'h0;
	endtask
	task automatic rdck(input addr_t a, input word_t e, input string n);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1'h1;
		@(posedge clk);
		rdStrobe <= 1'h0;
		#1;
		`CK(n, e, rdData)
	endtask
	// conversion pulses with a gap, then let events settle
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk);
			conversionDone <= 1'h1;
			@(posedge clk);
			conversionDone <= 1'h0;
		end
		tick(3);
	endtask
	task automatic close_out;
		if (miscompares == 0 && checkCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		close_out;
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'h1;
		addr = 4'h0;
		wrData = 16'h0000;
		wrStrobe = 1'h0;
		rdStrobe = 1'h0;
		conversionDone = 1'h0;
		twelveBitMode = 1'h0;
		dmaAddressModeEnable = 1'h0;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		rdck(4'h0, 16'h0000, "ctl reset");
		rdck(4'h3, 16'h0000, "mask reset");
		wr(4'h9, 16'hffff);
		rdck(4'h9, 16'h0000, "unmapped");
		for (int i = 0; i < 8; i++) begin
			wr(4'h0, {i[2:0], 13'h0000});
			tick(2);
			`CK("ref high", (i == 1 || i == 3), refHighExternal)
			`CK("ref low", (i == 2 || i == 3), refLowExternal)
		end
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			twelveBitMode <= i[2];
			wr(4'h0, {6'h00, i[1:0], 8'h00});
			tick(2);
			`CK("chan en", i[2] ? 4'h1 : (i[1] ? 4'hf : {2'h0, i[0], 1'h1}), channelEnable)
			rdck(4'h0, {6'h00, i[2] ? 2'h0 : i[1:0], 8'h00}, "chan rd");
		end
		@(posedge clk);
		twelveBitMode <= 1'h0;
		wr(4'h0, 16'hffff);
		rdck(4'h0, 16'he77f, "ctl mask");
		wr(4'h3, 16'h0001);
		foreach (nv[k]) begin
			wr(4'h0, {9'h000, 1'h1, nv[k][3:0], 2'h0});
			pulse(nv[k]);
			`CK("irq idle", 1'h0, interrupt)
			rdck(4'h2, 16'h0000, "early status");
			pulse(1);
			`CK("irq", 1'h1, interrupt)
			rdck(4'h2, 16'h0001, "status");
			tick(3);
			`CK("irq clr", 1'h0, interrupt)
		end
		wr(4'h3, 16'h0000);
		pulse(16);
		`CK("masked irq", 1'h0, interrupt)
		rdck(4'h2, 16'h0001, "masked status");
		wr(4'h3, 16'h0001);
		@(posedge clk);
		dmaAddressModeEnable <= 1'h1;
		wr(4'h0, 16'h0040);
		pulse(16);
		`CK("dma early", 0, dmaSeen)
		pulse(1);
		`CK("dma step", 1, dmaSeen)
		`CK("dma no irq", 1'h0, interrupt)
		rdck(4'h2, 16'h0002, "dma status");
		@(posedge clk);
		dmaAddressModeEnable <= 1'h0;
		wr(4'h3, 16'h0004);
		wr(4'h0, 16'h0002);
		pulse(1);
		`CK("half", 1'h1, bufferHalf)
		`CK("half irq", 1'h1, interrupt)
		rdck(4'h2, 16'h0005, "half status");
		rdck(4'h0, 16'h0082, "half rd");
		pulse(1);
		`CK("half back", 1'h0, bufferHalf)
		pulse(1);
		wr(4'h0, 16'h0000);
		tick(2);
		`CK("half off", 1'h0, bufferHalf)
		wr(4'h1, 16'h0014);
		wr(4'h0, 16'h0400);
		tick(3);
		`CK("scan on", 1'h1, scanActive)
		`CK("scan first", 4'h2, scanInput)
		pulse(1);
		`CK("scan next", 4'h4, scanInput)
		pulse(1);
		`CK("scan wrap", 4'h2, scanInput)
		wr(4'h0, 16'h0401);
		tick(2);
		`CK("alt first", 4'h2, scanInput)
		pulse(1);
		`CK("alt mux b", 1'h1, muxBActive)
		`CK("alt scan idle", 1'h0, scanActive)
		`CK("alt step", 4'h4, scanInput)
		pulse(1);
		`CK("alt mux a", 1'h0, muxBActive)
		`CK("alt hold", 4'h4, scanInput)
		wr(4'h0, 16'h0000);
		tick(3);
		`CK("scan off", 1'h0, scanActive)
		@(posedge clk);
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		rdck(4'h3, 16'h0000, "mask after reset");
		`CK("irq after reset", 1'h0, interrupt)
		`CK("scan after reset", 4'hf, scanInput)
		close_out;
	end
endmodule
